// ---- inc/sas_consts.svh ----
// Register map, field positions, reset values and timing bases
`ifndef SAS_CONSTS_SVH
`define SAS_CONSTS_SVH
`define SAS_OFF_CTL 12'h000
`define SAS_OFF_CFG 12'h004
`define SAS_OFF_PDN 12'h008
`define SAS_OFF_DATA 12'h040
`define SAS_CTL_FLAG 7
`define SAS_CTL_IE 6
`define SAS_CTL_START 5
`define SAS_CTL_CH 0
`define SAS_CFG_TRG 6
`define SAS_CFG_SCAN 4
`define SAS_CFG_CKS 2
`define SAS_RST_CTL 8'h00
`define SAS_RST_CFG 8'h00
`define SAS_RST_PDN 16'h0000
// Timings in states (one state = one mclk cycle); bases shifted right by clock select, adders added unshifted after
`define SAS_DLY_BASE 16
`define SAS_DLY_ADD 2
`define SAS_SPL_BASE 128
`define SAS_CMP_BASE 368
`define SAS_CMP_ADD 2
`define SAS_GAP_BASE 16
`define SAS_SAR_MSB 10'h200
`endif

// ---- inc/sas_pkg.sv ----
// Types shared by the converter sequencer
package sas_pkg;
    typedef enum logic [2:0] {SAS_IDLE, SAS_DELAY, SAS_SAMPLE, SAS_CONVERT, SAS_GAP} sas_state_t;
    typedef struct packed {
        logic end_flag;
        logic irq_en;
        logic start;
        logic [3:0] chan;
    } sas_ctl_t;
    typedef struct packed {
        logic [1:0] trig_sel;
        logic [1:0] scan_mode;
        logic [1:0] clk_sel;
    } sas_cfg_t;
endpackage

// ---- rtl/sas_sequencer.sv ----
// Successive-approximation converter sequencer with APB registers
`timescale 1ns/1ps
`include "sas_consts.svh"
module sas_sequencer #(
    parameter int NCH = 16,
    parameter int RES = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Start triggers
    input wire logic timer_pulse_unit_trg,
    input wire logic external_trigger_pin_n,
    // Analog front end
    input wire logic cmp_in,
    output logic [9:0] dac_code,
    output logic sample_en,
    output logic [3:0] channel_sel,
    output logic [15:0] pulldown_en,
    // Event output
    output logic conversion_end_interrupt
);
    if (NCH != 16 || RES != 10)
    begin : g_chk
        $error("sas_sequencer supports only 16 channels of 10 bits");
    end

    sas_pkg::sas_state_t state_r, state_nxt;
    sas_pkg::sas_ctl_t ctl_r, ctl_nxt;
    sas_pkg::sas_cfg_t cfg_r;
    logic [15:0] pdn_r;
    logic [9:0] cnt_r, cnt_nxt;
    logic [9:0] sar_r, sar_nxt;
    logic [3:0] cur_r, cur_nxt;
    logic [3:0] free_r;
    logic [31:0] prdata_r;
    logic [9:0] data_r [16];
    logic trg_s1_r, trg_s2_r, trg_s3_r, trg_lvl_r;

    // APB decode
    wire apb_wr = psel & penable & pwrite;
    wire apb_setup = psel & ~penable;
    wire hit_ctl = paddr == `SAS_OFF_CTL;
    wire hit_cfg = paddr == `SAS_OFF_CFG;
    wire hit_pdn = paddr == `SAS_OFF_PDN;
    wire hit_data = (paddr[11:6] == 6'(`SAS_OFF_DATA >> 6)) && (paddr[1:0] == 2'b00);
    wire addr_ok = hit_ctl | hit_cfg | hit_pdn | hit_data;
    wire wr_ctl = apb_wr & hit_ctl;
    wire wr_cfg = apb_wr & hit_cfg;
    wire wr_pdn = apb_wr & hit_pdn;
    wire sw_set = wr_ctl & pwdata[`SAS_CTL_START];
    wire sw_clr = wr_ctl & ~pwdata[`SAS_CTL_START];
    wire [31:0] rd_data = hit_ctl ? {24'h00_0000, ctl_r.end_flag, ctl_r.irq_en, ctl_r.start,
        1'b0, ctl_r.chan} :
        hit_cfg ? {24'h00_0000, cfg_r, 2'b00} :
        hit_pdn ? {16'h0000, pdn_r} :
        hit_data ? {22'h00_0000, data_r[paddr[5:2]]} : 32'h0000_0000;

    // Trigger selection
    wire ext_fall = (trg_s2_r == trg_s3_r) & ~trg_s2_r & trg_lvl_r;
    wire trig_hit = (cfg_r.trig_sel == 2'b01 & timer_pulse_unit_trg) |
        (cfg_r.trig_sel == 2'b11 & ext_fall);

    // Channel group bounds
    wire scan_on = cfg_r.scan_mode[1];
    wire [3:0] grp_first = ~scan_on ? ctl_r.chan :
        ~cfg_r.scan_mode[0] ? {ctl_r.chan[3:2], 2'b00} :
        {ctl_r.chan[3], 3'b000};
    wire [3:0] grp_last = ~scan_on ? ctl_r.chan :
        ~cfg_r.scan_mode[0] ? {ctl_r.chan[3:2], ctl_r.chan[1:0]} :
        {ctl_r.chan[3], ctl_r.chan[2:0]};
    wire last_hit = cur_r == grp_last;

    // Phase lengths from clock select
    wire [1:0] cks = cfg_r.clk_sel;
    wire [9:0] span = 10'((`SAS_GAP_BASE >> cks) - 1);
    wire [9:0] dly_min = 10'((`SAS_DLY_BASE >> cks) + `SAS_DLY_ADD);
    wire [9:0] dly_len = dly_min + (10'(free_r) & span);
    wire [9:0] spl_len = 10'((`SAS_SPL_BASE >> cks) - 1);
    wire [9:0] cmp_len = 10'((`SAS_CMP_BASE >> cks) + `SAS_CMP_ADD);

    // Conversion end events
    wire conv_end = (state_r == sas_pkg::SAS_CONVERT) & (cnt_r == 10'h000) & ctl_r.start;
    wire grp_end = conv_end & (~scan_on | last_hit);
    wire [9:0] result = {sar_r[9:1], cmp_in};
    wire [9:0] sar_bit = 10'(10'h001 << cnt_r[3:0]);
    wire sar_dec = (state_r == sas_pkg::SAS_CONVERT) & (cnt_r < 10'd10);

    // Start, flag and control register
    always_comb
    begin
        ctl_nxt = ctl_r;
        if (wr_ctl)
        begin
            ctl_nxt.irq_en = pwdata[`SAS_CTL_IE];
            ctl_nxt.chan = pwdata[`SAS_CTL_CH +: 4];
        end
        if (sw_clr)
            ctl_nxt.start = 1'b0;
        else if (sw_set | trig_hit)
            ctl_nxt.start = 1'b1;
        else if (conv_end & ~scan_on)
            ctl_nxt.start = 1'b0;
        // Set wins over the write-zero clear
        ctl_nxt.end_flag = grp_end | (ctl_r.end_flag & ~(wr_ctl & ~pwdata[`SAS_CTL_FLAG]));
    end

    // Sequencer state machine
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r - 10'd1;
        cur_nxt = cur_r;
        sar_nxt = sar_r;
        case (state_r)
            sas_pkg::SAS_IDLE:
            begin
                cnt_nxt = dly_len - 10'd1;
                cur_nxt = grp_first;
                if (ctl_r.start)
                    state_nxt = sas_pkg::SAS_DELAY;
            end
            sas_pkg::SAS_DELAY, sas_pkg::SAS_GAP:
                if (cnt_r == 10'h000)
                begin
                    state_nxt = sas_pkg::SAS_SAMPLE;
                    cnt_nxt = spl_len - 10'd1;
                end
            sas_pkg::SAS_SAMPLE:
                if (cnt_r == 10'h000)
                begin
                    state_nxt = sas_pkg::SAS_CONVERT;
                    cnt_nxt = cmp_len - 10'd1;
                    sar_nxt = `SAS_SAR_MSB;
                end
            sas_pkg::SAS_CONVERT:
            begin
                if (sar_dec)
                    sar_nxt = (cmp_in ? sar_r : sar_r & ~sar_bit) | (sar_bit >> 1);
                if (cnt_r == 10'h000)
                begin
                    if (scan_on)
                    begin
                        state_nxt = sas_pkg::SAS_GAP;
                        cnt_nxt = span - 10'd1;
                        cur_nxt = last_hit ? grp_first : cur_r + 4'd1;
                    end
                    else
                        state_nxt = sas_pkg::SAS_IDLE;
                end
            end
            default:
                state_nxt = sas_pkg::SAS_IDLE;
        endcase
        if (!ctl_r.start)
            state_nxt = sas_pkg::SAS_IDLE;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= sas_pkg::SAS_IDLE;
            cnt_r <= 10'h000;
            sar_r <= 10'h000;
            cur_r <= 4'h0;
            free_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sar_r <= sar_nxt;
            cur_r <= cur_nxt;
            free_r <= free_r + 4'd1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctl_r <= sas_pkg::sas_ctl_t'({3'(`SAS_RST_CTL >> `SAS_CTL_START), 4'(`SAS_RST_CTL)});
            cfg_r <= sas_pkg::sas_cfg_t'(6'(`SAS_RST_CFG >> `SAS_CFG_CKS));
            pdn_r <= `SAS_RST_PDN;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            if (wr_cfg)
                cfg_r <= pwdata[`SAS_CFG_CKS +: 6];
            if (wr_pdn)
                pdn_r <= pwdata[15:0];
            if (apb_setup)
                prdata_r <= rd_data;
        end
    end

    // External trigger pin synchroniser
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            trg_s1_r <= 1'b1;
            trg_s2_r <= 1'b1;
            trg_s3_r <= 1'b1;
            trg_lvl_r <= 1'b1;
        end
        else
        begin
            trg_s1_r <= external_trigger_pin_n;
            trg_s2_r <= trg_s1_r;
            trg_s3_r <= trg_s2_r;
            if (trg_s2_r == trg_s3_r)
                trg_lvl_r <= trg_s2_r;
        end
    end

    // Per-channel result registers
    for (genvar i = 0; i < NCH; i++)
    begin : g_data
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
                data_r[i] <= 10'h000;
            else if (conv_end && cur_r == 4'(i))
                data_r[i] <= result;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign dac_code = sar_r;
    assign sample_en = state_r == sas_pkg::SAS_SAMPLE;
    assign channel_sel = cur_r;
    assign pulldown_en = pdn_r;
    assign conversion_end_interrupt = ctl_r.end_flag & ctl_r.irq_en;

    property p_pdn;
        @(posedge mclk) disable iff (!rstn) wr_pdn |=> pulldown_en == $past(pwdata[15:0]);
    endproperty
    a_pdn: assert property (p_pdn)
        else $error("pull-down not updated");

    property p_msb;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_CONVERT && cnt_r > 10'd10) |-> dac_code == 10'h200;
    endproperty
    a_msb: assert property (p_msb)
        else $error("trial code wrong before decisions");

    property p_trial;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_CONVERT && cnt_r < 10'd10) |-> dac_code[cnt_r[3:0]];
    endproperty
    a_trial: assert property (p_trial)
        else $error("trial bit not raised during decision");

    property p_result;
        @(posedge mclk) disable iff (!rstn)
            conv_end |=> data_r[$past(cur_r)] == $past(result);
    endproperty
    a_result: assert property (p_result)
        else $error("result not stored");

    property p_flag;
        @(posedge mclk) disable iff (!rstn)
            (grp_end && ctl_r.irq_en && !wr_ctl) |=> ctl_r.end_flag && conversion_end_interrupt;
    endproperty
    a_flag: assert property (p_flag)
        else $error("end flag or interrupt missing");

    property p_single;
        @(posedge mclk) disable iff (!rstn)
            (conv_end && !scan_on && !wr_ctl && !trig_hit) |=> !ctl_r.start ##1
                state_r == sas_pkg::SAS_IDLE;
    endproperty
    a_single: assert property (p_single)
        else $error("single start did not clear");

    property p_abort;
        @(posedge mclk) disable iff (!rstn)
            !ctl_r.start |=> state_r == sas_pkg::SAS_IDLE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("cleared start did not stop conversion");

    property p_first;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_IDLE && ctl_r.start) |=> channel_sel == $past(grp_first);
    endproperty
    a_first: assert property (p_first)
        else $error("conversion did not begin at group start");

    property p_wrap;
        @(posedge mclk) disable iff (!rstn)
            (conv_end && scan_on && last_hit && !wr_ctl && !wr_cfg) |=>
                cur_r == grp_first && ctl_r.start;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("scan did not restart group");

    property p_scan_hold;
        @(posedge mclk) disable iff (!rstn)
            (scan_on && ctl_r.start && !sw_clr) |=> ctl_r.start;
    endproperty
    a_scan_hold: assert property (p_scan_hold)
        else $error("scan start cleared itself");

    property p_delay;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_IDLE && ctl_r.start && !wr_cfg) |=>
                cnt_r + 10'd1 >= dly_min && cnt_r + 10'd1 <= dly_min + span;
    endproperty
    a_delay: assert property (p_delay)
        else $error("start delay out of range");

    property p_spl;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_SAMPLE && $past(state_r) != sas_pkg::SAS_SAMPLE)
                |-> cnt_r == spl_len - 10'd1;
    endproperty
    a_spl: assert property (p_spl)
        else $error("sampling length wrong");

    property p_gap;
        @(posedge mclk) disable iff (!rstn)
            (state_r == sas_pkg::SAS_GAP && $past(state_r) == sas_pkg::SAS_CONVERT &&
                !$past(wr_cfg)) |-> cnt_r == span - 10'd1;
    endproperty
    a_gap: assert property (p_gap)
        else $error("scan gap length wrong");

    property p_ext;
        @(posedge mclk) disable iff (!rstn)
            (cfg_r.trig_sel == 2'b11 && ext_fall && !sw_clr) |=> ctl_r.start;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external edge did not start");

    property p_timer;
        @(posedge mclk) disable iff (!rstn)
            (cfg_r.trig_sel == 2'b01 && timer_pulse_unit_trg && !sw_clr) |=> ctl_r.start;
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer trigger did not start");

    property p_prohib;
        @(posedge mclk) disable iff (!rstn)
            (cfg_r.trig_sel == 2'b10 && !ctl_r.start && !sw_set) |=> !ctl_r.start;
    endproperty
    a_prohib: assert property (p_prohib)
        else $error("prohibited trigger code started");
endmodule // sas_sequencer

// ---- tb/sas_analog_model.sv ----
// Comparator model of the analog inputs
`timescale 1ns/1ps
module sas_analog_model (
    // Converter side
    input wire logic [3:0] channel_sel,
    input wire logic [9:0] dac_code,
    input wire logic [15:0] pulldown_en,
    // Input levels, ten bits per channel
    input wire logic [159:0] levels,
    output logic cmp_in
);
    logic [9:0] level;
    // Pulled-down input reads as ground
    assign level = pulldown_en[channel_sel] ? 10'h000 : levels[channel_sel*10 +: 10];
    assign cmp_in = level >= dac_code;
endmodule // sas_analog_model

// ---- tb/sas_sequencer_tb.sv ----
// Register-level bench of the converter sequencer
`timescale 1ns/1ps
`include "sas_consts.svh"
module sas_sequencer_tb;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr, cmp_in, sample_en, irq;
    logic timer_trg, ext_trg_n, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] dac_code;
    logic [3:0] channel_sel;
    logic [15:0] pulldown_en;
    logic [159:0] levels;
    int error_cnt, comparisons, cyc, n, spl_run, spl_seen;

    sas_sequencer i_sas_sequencer (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_pulse_unit_trg(timer_trg), .external_trigger_pin_n(ext_trg_n),
        .cmp_in(cmp_in), .dac_code(dac_code), .sample_en(sample_en),
        .channel_sel(channel_sel), .pulldown_en(pulldown_en),
        .conversion_end_interrupt(irq));
    sas_analog_model i_sas_analog_model (.channel_sel(channel_sel), .dac_code(dac_code),
        .pulldown_en(pulldown_en), .levels(levels), .cmp_in(cmp_in));

    function automatic logic [9:0] lvl(input int ch);
        return 10'h3A7 - 10'(ch * 47);
    endfunction

    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered right after a rising edge; holds the request until pready
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge: results settle and calls never overlap
        @(posedge mclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0000_0000, irq}, 32'h0000_0001);
    endtask

    // Length of the last sampling window
    always @(posedge mclk)
        if (sample_en === 1'b1)
            spl_run <= spl_run + 1;
        else if (spl_run != 0)
        begin
            spl_seen <= spl_run;
            spl_run <= 0;
        end

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            conclude();
        end
    end

    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        timer_trg = 1'b0;
        ext_trg_n = 1'b1;
        for (int i = 0; i < 16; i++)
            levels[i*10 +: 10] = lvl(i);
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd(`SAS_OFF_CTL, 32'h0000_0000);
        rd(`SAS_OFF_CFG, 32'h0000_0000);
        rd(`SAS_OFF_PDN, 32'h0000_0000);
        xfer(`SAS_OFF_PDN, 1'b1, 32'h0000_A5C3);
        chk(pulldown_en, 32'h0000_A5C3);
        rd(`SAS_OFF_PDN, 32'h0000_A5C3);
        xfer(`SAS_OFF_PDN, 1'b1, 32'h0000_0000);
        rd(12'h0FC, 32'h0000_0000);
        chk(e, 1);
        // Abort a long conversion part way
        wr(`SAS_OFF_CTL, 8'h23);
        repeat (50) @(posedge mclk);
        wr(`SAS_OFF_CTL, 8'h03);
        repeat (600) @(posedge mclk);
        rd(`SAS_OFF_CTL, 32'h0000_0003);
        rd(`SAS_OFF_DATA + 12'h00C, 32'h0000_0000);
        // Single conversion, fastest clock select
        wr(`SAS_OFF_CFG, 8'h0C);
        wr(`SAS_OFF_CTL, 8'h65);
        wait_irq();
        chk(32'(n >= 67 && n <= 71), 1);
        chk(spl_seen, 15);
        rd(`SAS_OFF_CTL, 32'h0000_00C5);
        rd(`SAS_OFF_DATA + 12'h014, {22'h00_0000, lvl(5)});
        wr(`SAS_OFF_CTL, 8'h45);
        chk(irq, 0);
        // Three-channel scan over inputs 4 to 6
        wr(`SAS_OFF_CFG, 8'h2C);
        wr(`SAS_OFF_CTL, 8'h66);
        wait_irq();
        wr(`SAS_OFF_CTL, 8'h66);
        wait_irq();
        chk(32'(n >= 189 && n <= 191), 1);
        rd(`SAS_OFF_CTL, 32'h0000_00E6);
        for (int c = 4; c < 7; c++)
            rd(`SAS_OFF_DATA + 12'(4 * c), {22'h00_0000, lvl(c)});
        // Two-channel scan from input 8
        wr(`SAS_OFF_CTL, 8'h40);
        wr(`SAS_OFF_CFG, 8'h3C);
        wr(`SAS_OFF_CTL, 8'h69);
        wait_irq();
        rd(`SAS_OFF_DATA + 12'h020, {22'h00_0000, lvl(8)});
        rd(`SAS_OFF_DATA + 12'h024, {22'h00_0000, lvl(9)});
        // External pin trigger
        wr(`SAS_OFF_CTL, 8'h42);
        wr(`SAS_OFF_CFG, 8'hCC);
        ext_trg_n <= 1'b0;
        wait_irq();
        chk(32'(n < 3000), 1);
        rd(`SAS_OFF_DATA + 12'h008, {22'h00_0000, lvl(2)});
        ext_trg_n <= 1'b1;
        // Timer trigger
        wr(`SAS_OFF_CTL, 8'h47);
        wr(`SAS_OFF_CFG, 8'h4C);
        timer_trg <= 1'b1;
        @(posedge mclk);
        timer_trg <= 1'b0;
        wait_irq();
        rd(`SAS_OFF_CTL, 32'h0000_00C7);
        rd(`SAS_OFF_DATA + 12'h01C, {22'h00_0000, lvl(7)});
        // Disabled and prohibited trigger codes never start
        for (int t = 0; t < 2; t++)
        begin
            wr(`SAS_OFF_CTL, 8'h41);
            wr(`SAS_OFF_CFG, 8'(t * 128 + 12));
            timer_trg <= 1'b1;
            ext_trg_n <= 1'b0;
            @(posedge mclk);
            timer_trg <= 1'b0;
            repeat (150) @(posedge mclk);
            ext_trg_n <= 1'b1;
            rd(`SAS_OFF_CTL, 32'h0000_0041);
        end
        conclude();
    end
endmodule // sas_sequencer_tb
